// ### rtl/rid_pkg.sv
// Package for the instruction decoder: opcodes, addresses and timing.
// Assumes a 125 MHz system clock with four phases per instruction cycle.
package rid_pkg;
   localparam int unsigned RID_CLK_MHZ = 125;
   localparam int unsigned RID_PHASES = 4;
   localparam logic [1:0] RID_PHASE_LAST = 2'h3;
   localparam logic [11:0] RID_ADDR_WORKING = 12'hfe8;
   localparam logic [11:0] RID_ADDR_PROD_LO = 12'hff3;
   localparam logic [11:0] RID_ADDR_PROD_HI = 12'hff4;
   localparam logic [11:0] RID_ADDR_TBL_LATCH = 12'hff5;
   localparam logic [11:0] RID_ADDR_TBL_PTR = 12'hff6;
   localparam logic [11:0] RID_ADDR_PC_LOW = 12'hff9;
   localparam logic [11:0] RID_ADDR_PC_HIGH = 12'hffa;
   localparam logic [11:0] RID_ADDR_PC_UPPER = 12'hffb;
   localparam logic [11:0] RID_ADDR_TIMER0 = 12'hfd6;
   localparam logic [11:0] RID_ADDR_PORT = 12'hf81;
   localparam logic [3:0] RID_OP_MOVE2 = 4'hc;
   localparam logic [3:0] RID_OP_SECOND = 4'hf;
   localparam logic [3:0] RID_OP_BRANCH = 4'he;
   localparam logic [7:0] RID_OP_CALL = 8'hec;
   localparam logic [7:0] RID_OP_GOTO = 8'hef;
   localparam logic [7:0] RID_OP_LOADPTR = 8'hee;
   localparam logic [7:0] RID_OP_ADD_LIT = 8'h0f;
   localparam logic [7:0] RID_OP_AND_LIT = 8'h0b;
   localparam logic [7:0] RID_OP_MUL_LIT = 8'h0d;
   localparam logic [6:0] RID_OP_MUL_REG = 7'h01;
   localparam logic [6:0] RID_OP_CMP_LT = 7'h30;
   localparam logic [6:0] RID_OP_CMP_EQ = 7'h31;
   localparam logic [6:0] RID_OP_CMP_GT = 7'h32;
   localparam logic [11:0] RID_OP_LOADBANK = 12'h010;
   localparam logic [15:0] RID_W_NOP = 16'h0000;
   localparam logic [15:0] RID_W_SLEEP = 16'h0003;
   localparam logic [15:0] RID_W_WDCLR = 16'h0004;
   localparam logic [15:0] RID_W_SWRESET = 16'h00ff;
   localparam logic [14:0] RID_W_RETURNS = 15'h0008;
   localparam logic [13:0] RID_W_TABLE_READ_OP = 14'h0002;
   localparam logic [13:0] RID_W_TABLE_WRITE_OP = 14'h0003;
   localparam logic [20:0] RID_TABLE_POINTER_RST = 21'h000000;
   localparam logic [3:0] RID_BANK_RST = 4'h0;
   typedef enum logic [3:0] {
      RID_S_FETCH = 4'b0001,
      RID_S_SECOND = 4'b0010,
      RID_S_FLUSH = 4'b0100,
      RID_S_TWRITE = 4'b1000
   } rid_state_t;
endpackage : rid_pkg

// ### rtl/rid_phase_gen.sv
// Four-phase sequencer giving one step enable per instruction cycle.
// Assumes one system clock; all phases are enables, not clocks.
`timescale 1ns/100ps
module rid_phase_gen
   import rid_pkg::*;
(
   input wire logic sys_clk,
   input wire logic reset,
   output logic [1:0] phase,
   output logic step
);
   logic [1:0] phase_r;
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         phase_r <= 2'h0;
      end else begin
         phase_r <= phase_r + 2'h1;
      end
   end
   assign phase = phase_r;
   assign step = (phase_r == RID_PHASE_LAST);
endmodule // rid_phase_gen

// ### rtl/rid_pin_sync.sv
// Two-flop synchroniser for the port pin levels.
// Assumes pins are asynchronous to sys_clk.
`timescale 1ns/100ps
module rid_pin_sync (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic [7:0] pin_async,
   output logic [7:0] pin_sync
);
   logic [7:0] meta_r;
   logic [7:0] sync_r;
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         meta_r <= 8'h00;
         sync_r <= 8'h00;
      end else begin
         meta_r <= pin_async;
         sync_r <= meta_r;
      end
   end
   assign pin_sync = sync_r;
endmodule // rid_pin_sync

// ### rtl/rid_decoder.sv
// Instruction decoder for the 8-bit core: fields, cycle count, side effects.
// Assumes the fetch path presents the next word on instr_word and the
// datapath returns branch and compare conditions within the same cycle.
// Behaviour
// [RULE1] Byte op: opcode, destination, access, address
// [RULE2] Access bit zero forces the access bank
// [RULE3] Two-word register move, 12-bit addresses
// [RULE4] Bit op: bit position, access, address
// [RULE5] Literal op: upper byte op, lower literal
// [RULE6] Jump and call assemble 20-bit target
// [RULE7] Returns with fast bit, two cycles (code flushes only the RID_W_RETURNS word; the other return takes one cycle)
// [RULE8] Conditional branch with eight condition codes
// [RULE9] Taken change of flow adds a nop
// [RULE10] Orphan second word runs as nop
// [RULE11] Prefix 1111 and zero word are nops
// [RULE12] Port self-modify reads sampled pins
// [RULE13] Timer zero write clears its prescaler
// [RULE14] Internal memory write runs until terminated
// [RULE15] Table reads: four pointer modes, two cycles
// [RULE16] Table writes: same modes, two or more
// [RULE17] 21-bit table pointer and 8-bit latch
// [RULE18] Load pointer: two words, 12-bit literal
// [RULE19] Load bank literal into low nibble
// [RULE20] Multiplies are single cycle, no flags
// [RULE21] Compare-skip equal, greater, less
// [RULE22] Standby, watchdog clear, software reset
// [RULE23] Four oscillator periods per cycle
// [RULE24] Branch target is pc plus twice offset
// [RULE25] Product lands in high and low bytes
// [RULE26] Unlisted words are single-cycle nops
// [RULE27] Controls held stable for whole cycle
`timescale 1ns/100ps
module rid_decoder
   import rid_pkg::*;
(
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic [15:0] instr_word,
   input wire logic [20:0] pc_now,
   input wire logic [3:0] status_nzvc,
   input wire logic skip_cond,
   input wire logic nvm_write_start,
   input wire logic nvm_write_done,
   input wire logic timer0_prescale_assigned,
   input wire logic [7:0] port_pins,
   input wire logic tbl_ptr_we,
   input wire logic [20:0] tbl_ptr_wdata,
   input wire logic tbl_latch_we,
   input wire logic [7:0] tbl_latch_wdata,
   output logic step_en,
   output logic [11:0] reg_addr,
   output logic [11:0] move_dst_addr,
   output logic dest_to_reg,
   output logic [2:0] bit_pos,
   output logic [7:0] literal,
   output logic [7:0] op_code,
   output logic pc_load,
   output logic [20:0] pc_target,
   output logic fast_mode,
   output logic irq_reenable,
   output logic exec_nop,
   output logic mul_en,
   output logic [11:0] mul_hi_addr,
   output logic [11:0] mul_lo_addr,
   output logic [1:0] ptr_sel,
   output logic [11:0] ptr_literal,
   output logic ptr_load,
   output logic [3:0] bank_sel,
   output logic use_pin_source,
   output logic [7:0] pin_value,
   output logic prescale_clr,
   output logic tbl_read,
   output logic tbl_write,
   output logic [20:0] tbl_ptr,
   output logic [7:0] tbl_latch,
   output logic standby_req,
   output logic wdt_clear,
   output logic sw_reset
);
   logic step;
   logic [7:0] pins_s;
   rid_state_t state_r;
   logic [15:0] first_r;
   logic [15:0] w;
   logic [3:0] bank_r;
   logic [20:0] table_pointer_r;
   logic [7:0] tbllat_r;
   logic [11:0] addr_c;
   logic taken_c;
   logic two_word_c;
   logic is_tbl_c;

   // Phase sequencer.
   // [RULE23] four phase step
   rid_phase_gen u_phase (
      .sys_clk(sys_clk),
      .reset(reset),
      .phase(),
      .step(step)
   );

   rid_pin_sync u_pins (
      .sys_clk(sys_clk),
      .reset(reset),
      .pin_async(port_pins),
      .pin_sync(pins_s)
   );

   function automatic logic branch_true(input logic [3:0] cc,
                                        input logic [3:0] nzvc);
      logic f;
      f = 1'b0;
      case (cc[2:1])
         2'h0: f = nzvc[2];
         2'h1: f = nzvc[0];
         2'h2: f = nzvc[1];
         default: f = nzvc[3];
      endcase
      return f ^ cc[0];
   endfunction

   // Full address: access bank or the selected bank.
   function automatic logic [11:0] bank_addr(input logic a,
                                             input logic [7:0] f,
                                             input logic [3:0] b);
      logic [11:0] r;
      r = {4'h0, f};
      if (a) begin
         r = {b, f};
      end else if (f[7]) begin
         r = {4'hf, f};
      end
      return r;
   endfunction

   // Words outside the encoding map run as plain single-cycle nops.
   function automatic logic listed_word(input logic [15:0] v);
      logic [7:0] lo;
      lo = v[7:0];
      return !((v[15:8] == 8'h00 && lo != 8'h00 && lo != 8'hff &&
                (lo < 8'h03 || lo > 8'h13)) ||
               (v[15:8] == 8'h01 && lo[7:4] != 4'h0) ||
               (v[15:10] == 6'h3a) ||
               (v[15:8] == RID_OP_LOADPTR && lo[7:6] != 2'h0));
   endfunction

   assign w = instr_word;
   // [RULE2] access bank select
   assign addr_c = bank_addr(w[8], w[7:0], bank_r);
   // [RULE8] branch condition decode
   assign taken_c = (w[15:12] == RID_OP_BRANCH) && !w[11] &&
                    branch_true(w[11:8], status_nzvc);
   assign two_word_c = (w[15:12] == RID_OP_MOVE2) ||
                       (w[15:8] == RID_OP_CALL) ||
                       (w[15:8] == RID_OP_CALL + 8'h01) ||
                       (w[15:8] == RID_OP_GOTO) ||
                       (w[15:8] == RID_OP_LOADPTR && w[7:6] == 2'h0);
   assign is_tbl_c = (w[15:2] == RID_W_TABLE_READ_OP) ||
                     (w[15:2] == RID_W_TABLE_WRITE_OP);

   ////////////////////////////////////////////////////////////////////////
   // Cycle sequencing: one step per instruction cycle, extra nop cycles.
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         state_r <= RID_S_FETCH;
         first_r <= RID_W_NOP;
      end else if (step) begin
         case (state_r)
            RID_S_FETCH: begin
               first_r <= w;
               // [RULE9] extra nop cycle
               if (two_word_c) begin
                  state_r <= RID_S_SECOND;
               end else if (taken_c || skip_cond || is_tbl_c ||
                            (w[15:11] == 5'h1a) ||
                            (w[15:1] == RID_W_RETURNS) ||
                            (w[15:8] == 8'h0c)) begin
                  state_r <= (w[15:2] == RID_W_TABLE_WRITE_OP) ?
                             RID_S_TWRITE : RID_S_FLUSH;
               end
            end
            RID_S_SECOND: begin
               state_r <= RID_S_FETCH;
            end
            RID_S_TWRITE: begin
               // [RULE14] hold while write runs
               if (!nvm_write_start || nvm_write_done) begin
                  state_r <= RID_S_FETCH;
               end
            end
            RID_S_FLUSH: begin
               state_r <= RID_S_FETCH;
            end
            default: begin
               state_r <= RID_S_FETCH;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Bank selector and table registers.
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         bank_r <= RID_BANK_RST;
      // [RULE19] load bank nibble
      end else if (step && state_r == RID_S_FETCH &&
                   w[15:4] == RID_OP_LOADBANK) begin
         bank_r <= w[3:0];
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         table_pointer_r <= RID_TABLE_POINTER_RST;
         tbllat_r <= 8'h00;
      end else begin
         // [RULE17] pointer and latch hold
         if (tbl_ptr_we) begin
            table_pointer_r <= tbl_ptr_wdata;
         end else if (step && state_r == RID_S_FETCH && is_tbl_c) begin
            // [RULE15] pointer mode update
            case (w[1:0])
               2'h1: table_pointer_r <= table_pointer_r + 21'h1;
               2'h2: table_pointer_r <= table_pointer_r - 21'h1;
               2'h3: table_pointer_r <= table_pointer_r + 21'h1;
               default: table_pointer_r <= table_pointer_r;
            endcase
         end
         if (tbl_latch_we) begin
            tbllat_r <= tbl_latch_wdata;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Decoded controls, registered once per cycle and held until next step.
   // [RULE27] held across phases
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         reg_addr <= 12'h000;
         move_dst_addr <= 12'h000;
         dest_to_reg <= 1'b0;
         bit_pos <= 3'h0;
         literal <= 8'h00;
         op_code <= 8'h00;
         pc_load <= 1'b0;
         pc_target <= 21'h000000;
         fast_mode <= 1'b0;
         irq_reenable <= 1'b0;
         exec_nop <= 1'b1;
         mul_en <= 1'b0;
         ptr_sel <= 2'h0;
         ptr_literal <= 12'h000;
         ptr_load <= 1'b0;
         use_pin_source <= 1'b0;
         prescale_clr <= 1'b0;
         tbl_read <= 1'b0;
         tbl_write <= 1'b0;
         standby_req <= 1'b0;
         wdt_clear <= 1'b0;
         sw_reset <= 1'b0;
      end else if (step) begin
         pc_load <= 1'b0;
         irq_reenable <= 1'b0;
         fast_mode <= 1'b0;
         mul_en <= 1'b0;
         ptr_load <= 1'b0;
         prescale_clr <= 1'b0;
         tbl_read <= 1'b0;
         tbl_write <= 1'b0;
         standby_req <= 1'b0;
         wdt_clear <= 1'b0;
         sw_reset <= 1'b0;
         use_pin_source <= 1'b0;
         exec_nop <= 1'b1;
         op_code <= w[15:8];
         // [RULE1] byte field split
         dest_to_reg <= w[9];
         reg_addr <= addr_c;
         // [RULE4] bit position field
         bit_pos <= w[11:9];
         // [RULE5] literal field
         literal <= w[7:0];
         if (state_r == RID_S_SECOND) begin
            exec_nop <= 1'b0;
            // [RULE3] second word destination
            if (first_r[15:12] == RID_OP_MOVE2) begin
               reg_addr <= first_r[11:0];
               move_dst_addr <= w[11:0];
            // [RULE18] pointer literal load
            end else if (first_r[15:8] == RID_OP_LOADPTR) begin
               ptr_sel <= first_r[5:4];
               ptr_literal <= {first_r[3:0], w[7:0]};
               ptr_load <= 1'b1;
            end else begin
               // [RULE6] 20-bit jump target
               pc_load <= 1'b1;
               pc_target <= {w[11:0], first_r[7:0], 1'b0};
               fast_mode <= first_r[8] & ~first_r[9];
            end
         end else if (state_r == RID_S_FETCH) begin
            // [RULE11] prefix and zero nops
            // [RULE10] orphan second word
            // [RULE26] unlisted words nop
            exec_nop <= (w[15:12] == RID_OP_SECOND) || (w == RID_W_NOP) ||
                        !listed_word(w);
            // [RULE24] relative branch target
            if (taken_c) begin
               pc_load <= 1'b1;
               pc_target <= pc_now + {{12{w[7]}}, w[7:0], 1'b0};
            end
            // [RULE7] return with fast bit
            if (w[15:1] == RID_W_RETURNS || w[15:1] ==
                RID_W_RETURNS + 15'h1) begin
               fast_mode <= w[0];
               irq_reenable <= (w[15:1] == RID_W_RETURNS);
            end
            // [RULE20] multiply single cycle
            if (w[15:8] == RID_OP_MUL_LIT || w[15:9] == RID_OP_MUL_REG) begin
               mul_en <= 1'b1;
            end
            // [RULE21] compare skip decode
            if (w[15:9] == RID_OP_CMP_EQ || w[15:9] == RID_OP_CMP_GT ||
                w[15:9] == RID_OP_CMP_LT) begin
               dest_to_reg <= 1'b0;
            end
            // [RULE16] table write start
            tbl_write <= (w[15:2] == RID_W_TABLE_WRITE_OP);
            tbl_read <= (w[15:2] == RID_W_TABLE_READ_OP);
            // [RULE22] standby and watchdog
            standby_req <= (w == RID_W_SLEEP);
            wdt_clear <= (w == RID_W_WDCLR);
            sw_reset <= (w == RID_W_SWRESET);
            // [RULE13] timer zero prescaler
            prescale_clr <= (addr_c == RID_ADDR_TIMER0) &&
                            timer0_prescale_assigned &&
                            w[15:12] != RID_OP_SECOND &&
                            (w[9] || w[15:12] == 4'h6 ||
                             w[15:12] == 4'h7 || w[15:13] == 3'h4);
            // [RULE12] pins as source
            use_pin_source <= (addr_c == RID_ADDR_PORT);
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         pin_value <= 8'h00;
         bank_sel <= RID_BANK_RST;
         tbl_ptr <= RID_TABLE_POINTER_RST;
         tbl_latch <= 8'h00;
         step_en <= 1'b0;
         mul_hi_addr <= RID_ADDR_PROD_HI;
         mul_lo_addr <= RID_ADDR_PROD_LO;
      end else begin
         pin_value <= pins_s;
         bank_sel <= bank_r;
         tbl_ptr <= table_pointer_r;
         tbl_latch <= tbllat_r;
         step_en <= step;
         // [RULE25] product byte addresses
         mul_hi_addr <= RID_ADDR_PROD_HI;
         mul_lo_addr <= RID_ADDR_PROD_LO;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks.
   // [RULE23] four phase step
   step_period_a: assert property (@(posedge sys_clk) disable iff (reset)
      step |=> !step [*3] ##1 step) else $error("step period wrong");
   // [RULE19] load bank nibble
   bank_load_a: assert property (@(posedge sys_clk) disable iff (reset)
      step && state_r == RID_S_FETCH && w[15:4] == RID_OP_LOADBANK
      |=> bank_r == $past(w[3:0])) else $error("bank not loaded");
   // [RULE9] extra nop cycle
   taken_flush_a: assert property (@(posedge sys_clk) disable iff (reset)
      step && state_r == RID_S_FETCH && taken_c
      |=> state_r == RID_S_FLUSH) else $error("no flush after branch");
   // [RULE27] held across phases
   hold_ctl_a: assert property (@(posedge sys_clk) disable iff (reset)
      !$past(step) && !$rose(reset) |-> $stable(op_code))
      else $error("controls changed mid cycle");
   // [RULE3] second word destination
   move_two_a: assert property (@(posedge sys_clk) disable iff (reset)
      step && state_r == RID_S_FETCH && w[15:12] == RID_OP_MOVE2
      |=> state_r == RID_S_SECOND) else $error("move not two words");
   // [RULE22] standby and watchdog
   wdt_clear_a: assert property (@(posedge sys_clk) disable iff (reset)
      step && state_r == RID_S_FETCH && w == RID_W_WDCLR
      |=> wdt_clear) else $error("watchdog clear missed");
   // [RULE11] prefix and zero nops
   prefix_nop_a: assert property (@(posedge sys_clk) disable iff (reset)
      step && state_r == RID_S_FETCH && w[15:12] == RID_OP_SECOND
      |=> exec_nop && !pc_load) else $error("prefix word not nop");
   // [RULE14] hold while write runs
   twrite_hold_a: assert property (@(posedge sys_clk) disable iff (reset)
      state_r == RID_S_TWRITE && nvm_write_start && !nvm_write_done
      |=> state_r == RID_S_TWRITE) else $error("write hold lost");
endmodule // rid_decoder

// ### sim/rid_prog_mem.sv
// Program memory model on the fetch side of the instruction decoder.
// Assumes the bench loads mem before reset is released and that step_en
// pulses once per instruction cycle after the current word was taken.
`timescale 1ns/100ps
module rid_prog_mem (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic step_en,
   output logic [15:0] instr_word,
   output logic [20:0] pc_now
);
   logic [15:0] mem [0:63];
   logic [5:0] idx_r;

   ////////////////////////////////////////////////////////////////////////
   // The model does not follow jumps; words fetched in flush cycles must
   // be ignored by the decoder anyway.
   // one word per cycle
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         idx_r <= 6'h00;
      end else if (step_en) begin
         idx_r <= idx_r + 6'h01;
      end
   end

   assign instr_word = mem[idx_r];
   assign pc_now = {14'h0000, idx_r + 6'h01, 1'b0};
endmodule // rid_prog_mem

// ### sim/tb.sv
// Self-checking bench for the instruction decoder and a program memory.
// Assumes the decoder shows each word's controls after step_en and holds
// them until the next step.
`timescale 1ns/100ps
module tb;
   import rid_pkg::*;
   logic sys_clk, reset, skip_cond, tbl_ptr_we, tbl_latch_we, step_en;
   logic dest_to_reg, pc_load, fast_mode, irq_reenable, exec_nop, mul_en;
   logic ptr_load, use_pin_source, prescale_clr, tbl_read, tbl_write;
   logic standby_req, wdt_clear, sw_reset;
   logic nvm_write_start, nvm_write_done;
   logic [15:0] instr_word;
   logic [20:0] pc_now, pc_target, tbl_ptr, tbl_ptr_wdata;
   logic [11:0] reg_addr, move_dst_addr, mul_hi_addr, mul_lo_addr;
   logic [11:0] ptr_literal;
   logic [7:0] literal, op_code, pin_value, tbl_latch, tbl_latch_wdata;
   logic [2:0] bit_pos;
   logic [1:0] ptr_sel;
   logic [3:0] bank_sel;
   int n_mismatch, check_count, seed;
   localparam logic [15:0] PROG [0:38] = '{
      16'h0000, 16'h0f5a, 16'h0b3c, 16'h2612, 16'h2485, 16'h0105, 16'h2734,
      16'h9a12, 16'hf123, 16'h0d07, 16'h0003, 16'h0004, 16'h0009, 16'h0000,
      16'hee15, 16'hf0a7, 16'hef34, 16'hf012, 16'h0000, 16'he0fe, 16'h0000,
      16'he1fe, 16'h0000, 16'h6ed6, 16'h5281, 16'h0011, 16'h0000, 16'hc123,
      16'hf456, 16'h000d, 16'h0000, 16'h0f77, 16'h0f66, 16'h00ff, 16'h0000,
      16'h0000, 16'h0002, 16'h6212, 16'h0f11};

   rid_prog_mem rid_prog_mem_inst (.sys_clk, .reset, .step_en, .instr_word,
      .pc_now);

   rid_decoder rid_decoder_inst (.sys_clk, .reset, .instr_word, .pc_now,
      .status_nzvc(4'h4), .skip_cond, .nvm_write_start,
      .nvm_write_done, .timer0_prescale_assigned(1'b1),
      .port_pins(8'ha5), .tbl_ptr_we, .tbl_ptr_wdata, .tbl_latch_we,
      .tbl_latch_wdata, .step_en, .reg_addr, .move_dst_addr, .dest_to_reg,
      .bit_pos, .literal, .op_code, .pc_load, .pc_target, .fast_mode,
      .irq_reenable, .exec_nop, .mul_en, .mul_hi_addr, .mul_lo_addr,
      .ptr_sel, .ptr_literal, .ptr_load, .bank_sel, .use_pin_source,
      .pin_value, .prescale_clr, .tbl_read, .tbl_write, .tbl_ptr,
      .tbl_latch, .standby_req, .wdt_clear, .sw_reset);

   ////////////////////////////////////////////////////////////////////////
   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end

   function automatic logic [7:0] lit_of(input logic [15:0] w);
      return w[7:0];
   endfunction

   task automatic tally_and_finish;
      $display("checks %0d, mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count = check_count + 1;
      if (got !== exp) begin
         n_mismatch = n_mismatch + 1;
         $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask

   // Returns one negedge after step_en, when the new controls have settled.
   task automatic wait_step;
      int n;
      n = 0;
      @(negedge sys_clk);
      while (step_en !== 1'b1 && n < 20) begin
         @(negedge sys_clk);
         n = n + 1;
      end
      if (n >= 20) begin
         chk(32'h0, 32'h1);
         tally_and_finish();
      end
      @(negedge sys_clk);
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      n_mismatch = 0;
      check_count = 0;
      seed = 39691;
      reset = 1'b1;
      skip_cond = 1'b0;
      nvm_write_start = 1'b1;
      nvm_write_done = 1'b0;
      tbl_ptr_we = 1'b0;
      tbl_latch_we = 1'b0;
      tbl_ptr_wdata = 21'h000000;
      tbl_latch_wdata = 8'h00;
      for (int i = 0; i < 64; i++) begin
         rid_prog_mem_inst.mem[i] = (i < 39) ? PROG[i] : 16'h0000;
      end
      for (int i = 39; i < 47; i++) begin
         rid_prog_mem_inst.mem[i] = {8'h0f, 8'($random(seed))};
      end
      repeat (10) @(posedge sys_clk);
      @(negedge sys_clk);
      chk({exec_nop, pc_load, mul_hi_addr, mul_lo_addr},
          {1'b1, 1'b0, RID_ADDR_PROD_HI, RID_ADDR_PROD_LO});
      @(posedge sys_clk);
      reset <= 1'b0;
      tbl_ptr_we <= 1'b1;
      tbl_ptr_wdata <= 21'h1abcd;
      tbl_latch_we <= 1'b1;
      tbl_latch_wdata <= 8'h5c;
      @(posedge sys_clk);
      tbl_ptr_we <= 1'b0;
      tbl_latch_we <= 1'b0;
      for (int c = 0; c < 47; c++) begin
         wait_step();
         case (c)
            0: chk({exec_nop, tbl_latch}, {1'b1, 8'h5c});
            1: chk({exec_nop, op_code, literal},
                   {1'b0, 8'h0f, 8'h5a});
            2: chk({exec_nop, literal}, {1'b0, 8'h3c});
            3: chk({dest_to_reg, reg_addr},
                   {1'b1, 12'h012});
            4: chk({dest_to_reg, reg_addr},
                   {1'b0, 12'hf85});
            5: chk(bank_sel, 32'h5);
            6: chk(reg_addr, 32'h534);
            7: chk({bit_pos, reg_addr}, {3'h5, 12'h012});
            8: chk(exec_nop, 32'h1);
            9: chk({mul_en, mul_hi_addr, mul_lo_addr},
                   {1'b1, 12'hff4, 12'hff3});
            10: chk({standby_req, wdt_clear}, 32'h2);
            11: chk({standby_req, wdt_clear}, 32'h1);
            12: chk(tbl_read, 32'h1);
            13: chk(exec_nop, 32'h1);
            14: chk(tbl_ptr, 32'h1abce);
            15: chk({ptr_load, ptr_sel, ptr_literal},
                    {1'b1, 2'h1, 12'h5a7});
            17: chk({pc_load, pc_target}, {1'b1, 21'h02468});
            18: chk(exec_nop, 32'h1);
            19: chk({pc_load, pc_target}, {1'b1, 21'h24});
            20: chk(exec_nop, 32'h1);
            21: chk({pc_load, exec_nop}, 32'h0);
            23: chk({prescale_clr, reg_addr},
                    {1'b1, 12'hfd6});
            24: chk({use_pin_source, pin_value},
                    {1'b1, 8'ha5});
            25: chk({irq_reenable, fast_mode}, 32'h3);
            26: chk(exec_nop, 32'h1);
            28: chk({reg_addr, move_dst_addr},
                    {12'h123, 12'h456});
            29: chk(tbl_write, 32'h1);
            30: chk({tbl_write, exec_nop, tbl_ptr},
                    {1'b0, 1'b1, 21'h1abcf});
            31: chk(exec_nop, 32'h1);
            32: chk({exec_nop, literal}, {1'b0, 8'h66});
            33: chk({sw_reset, op_code}, {1'b1, 8'h00});
            36: chk(exec_nop, 32'h1);
            37: chk({dest_to_reg, reg_addr},
                    {1'b0, 12'h012});
            38: chk(exec_nop, 32'h1);
            default: if (c > 38) chk({exec_nop, literal},
               {1'b0, lit_of(rid_prog_mem_inst.mem[c])});
         endcase
         // The write is held open for one extra cycle, then reported done.
         if (c == 30 || c == 31 || c == 36 || c == 38) begin
            @(posedge sys_clk);
            skip_cond <= (c == 36);
            nvm_write_done <= (c == 30);
         end
      end
      tally_and_finish();
   end
endmodule // tb
